// >>> rtl/sse_pkg.sv
package sse_pkg;

    // ------------------------------------------------------------------
    // Register map as word indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0]  SSE_ADDR_ENTRY_30   = 8'h3E;
    localparam logic [7:0]  SSE_ADDR_ENTRY_31   = 8'h3F;
    localparam logic [7:0]  SSE_ADDR_STATUS     = 8'h40;
    localparam logic [7:0]  SSE_ADDR_WORD_BYTES = 8'h04;

    // ------------------------------------------------------------------
    // Entry field layout
    // ------------------------------------------------------------------
    localparam int          SSE_BIT_ACCESS      = 15;
    localparam int          SSE_SELF_HI         = 14;
    localparam int          SSE_SELF_LO         = 9;
    localparam int          SSE_BIT_RETURN      = 8;
    localparam int          SSE_SECOND_HI       = 7;
    localparam int          SSE_SECOND_LO       = 4;
    localparam int          SSE_FIRST_HI        = 3;
    localparam int          SSE_FIRST_LO        = 0;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [5:0]  SSE_SELF_30         = 6'h3E;
    localparam logic [5:0]  SSE_SELF_31         = 6'h3F;
    localparam logic [15:0] SSE_RESET_30        = 16'h7C00;
    localparam logic [15:0] SSE_RESET_31        = 16'h7E00;
    localparam int          SSE_NUM_ENTRIES     = 2;
    localparam logic [4:0]  SSE_FIRST_INDEX     = 5'h00;
    localparam logic [4:0]  SSE_INDEX_30        = 5'h1E;
    localparam logic [4:0]  SSE_INDEX_31        = 5'h1F;

    // ------------------------------------------------------------------
    // AHB-Lite codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  SSE_HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  SSE_HTRANS_SEQ      = 2'h3;

endpackage

// >>> rtl/sse_stack_entries.sv
`timescale 1ns/1ps
// Operation
// [RULE_01] Bit 15 of an entry selects access type: 0 read, 1 write.
// [RULE_02] Bits 14..9 hold the entry's own address, 111110b for entry 30, 111111b for 31.
// [RULE_03] With the return bit clear the sequencer steps to the next entry after conversion.
// [RULE_04] With the return bit set the sequencer goes back to the first entry after conversion.
// [RULE_05] Bits 7..4 choose the second converter's channel and reset to zero.
// [RULE_06] Bits 3..0 choose the first converter's channel and reset to zero.
// [RULE_07] Entry 31 sits at 0x3F and resets to 0x7E00.
// [RULE_08] Each entry gives one channel per converter for one paired conversion.
// [RULE_09] Reset returns the stack pointer to the first entry.
module sse_stack_entries
    import sse_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    input  wire logic [4:0]  stack_pointer_in,
    input  wire logic        conversion_done_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [4:0]       next_pointer_out,
    output logic             pointer_load_out,
    output logic [3:0]       first_converter_channel_out,
    output logic [3:0]       second_converter_channel_out
);

    typedef struct packed {
        logic [1:0][15:0] entry;
        logic             wr_pend;
        logic             rd_pend;
        logic [7:0]       addr;
        logic [31:0]      rdata;
        logic [4:0]       next_ptr;
        logic             load;
        logic [3:0]       first_ch;
        logic [3:0]       second_ch;
    } sse_state_s;

    sse_state_s st_q;
    sse_state_s st_d;

    // ------------------------------------------------------------------
    // Entry selected by the sequencer
    // ------------------------------------------------------------------
    logic        ptr_hit;
    logic        ptr_sel;
    logic [15:0] cur_entry;

    always_comb begin
        ptr_hit   = (stack_pointer_in == SSE_INDEX_30) || (stack_pointer_in == SSE_INDEX_31);
        ptr_sel   = (stack_pointer_in == SSE_INDEX_31);
        cur_entry = st_q.entry[ptr_sel];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.load = 1'b0;

        // Bus write data phase; self address and access bit are kept as
        // written so software reads back what it stored
        if (st_q.wr_pend) begin
            for (int i = 0; i < SSE_NUM_ENTRIES; i++) begin
                if (st_q.addr == (i == 0 ? SSE_ADDR_ENTRY_30 : SSE_ADDR_ENTRY_31)) begin
                    st_d.entry[i] = hwdata_in[15:0]; // [RULE_01] [RULE_02]
                end
            end
        end

        // Address phase capture; only word-aligned addresses decode, hsize_in is not checked
        st_d.wr_pend = 1'b0;
        st_d.rd_pend = 1'b0;
        // Misaligned byte addresses decode as unmapped so they never alias an entry
        if (hsel_in && hready_in && htrans_in[1]) begin
            st_d.addr    = (haddr_in[1:0] == 2'b00) ? haddr_in[9:2] : 8'hFF;
            st_d.wr_pend = hwrite_in;
            st_d.rd_pend = !hwrite_in;
            st_d.rdata   = 32'h0000_0000;
            case (st_d.addr)
                SSE_ADDR_ENTRY_30: st_d.rdata = {16'h0000, st_d.entry[0]};
                SSE_ADDR_ENTRY_31: st_d.rdata = {16'h0000, st_d.entry[1]}; // [RULE_07]
                SSE_ADDR_STATUS:   st_d.rdata = {19'h00000, st_q.next_ptr,
                                                 st_q.second_ch, st_q.first_ch};
                default:           st_d.rdata = 32'h0000_0000;
            endcase
        end

        // Sequencer step after a finished paired conversion
        if (conversion_done_in && ptr_hit) begin
            st_d.load = 1'b1;
            if (cur_entry[SSE_BIT_RETURN]) begin
                st_d.next_ptr = SSE_FIRST_INDEX; // [RULE_04]
            end else begin
                st_d.next_ptr = 5'(stack_pointer_in + 5'h01); // [RULE_03]
            end
        end

        // One channel per converter from the active entry
        if (ptr_hit) begin
            st_d.first_ch  = cur_entry[SSE_FIRST_HI:SSE_FIRST_LO];   // [RULE_06] [RULE_08]
            st_d.second_ch = cur_entry[SSE_SECOND_HI:SSE_SECOND_LO]; // [RULE_05] [RULE_08]
        end

        if (rst_in) begin
            st_d          = '0;
            st_d.entry[0] = SSE_RESET_30;
            st_d.entry[1] = SSE_RESET_31; // [RULE_07]
            st_d.next_ptr = SSE_FIRST_INDEX; // [RULE_09]
            st_d.load     = 1'b1;            // [RULE_09]
        end
    end

    always_ff @(posedge clock_in) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        hrdata_out                   = st_q.rdata;
        hreadyout_out                = 1'b1;
        hresp_out                    = 1'b0;
        next_pointer_out             = st_q.next_ptr;
        pointer_load_out             = st_q.load;
        first_converter_channel_out  = st_q.first_ch;
        second_converter_channel_out = st_q.second_ch;
    end

endmodule // sse_stack_entries

// >>> verification/sse_checker_asserts.sv
`timescale 1ns/1ps
module sse_checker (
    input wire logic        clock_in, rst_in, conversion_done_in, pointer_load_out,
    input wire logic        hreadyout_out, hresp_out,
    input wire logic [4:0]  stack_pointer_in, next_pointer_out,
    input wire logic [3:0]  first_converter_channel_out, second_converter_channel_out,
    input wire logic [31:0] hrdata_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Only entries 30 and 31 live here, other pointers belong to the rest of the stack
    wire hit = conversion_done_in && stack_pointer_in[4:1] == 4'hF;
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
    a_load_follows: assert property (hit |=> pointer_load_out)
        else $error("no load after conversion");
    a_load_cause: assert property (pointer_load_out |-> $past(rst_in) || $past(hit))
        else $error("load without cause");
    a_next_value: assert property (pointer_load_out && !$past(rst_in) |->
        next_pointer_out == 5'h00 || next_pointer_out == 5'($past(stack_pointer_in) + 5'h01))
        else $error("bad next pointer");
    a_reset_state: assert property (disable iff (1'b0) rst_in |=> pointer_load_out
        && next_pointer_out == 5'h00 && hrdata_out == 32'h0
        && first_converter_channel_out == 4'h0 && second_converter_channel_out == 4'h0)
        else $error("bad state after reset");
    a_pointer_held: assert property (!pointer_load_out |-> $stable(next_pointer_out))
        else $error("next pointer moved");
    a_channels_hold: assert property (!hit && stack_pointer_in[4:1] != 4'hF |=>
        $stable(first_converter_channel_out) && $stable(second_converter_channel_out))
        else $error("channels moved");
    a_upper_zero: assert property (hrdata_out[31:16] == 16'h0000)
        else $error("upper read bits set");
    c_return: cover property (pointer_load_out && next_pointer_out == 5'h00 && !$past(rst_in));
    c_advance: cover property (pointer_load_out && next_pointer_out == 5'h1F);
    c_channel: cover property (first_converter_channel_out != 4'h0);
endmodule // sse_checker
bind sse_stack_entries sse_checker sse_checker_inst (.clock_in, .rst_in, .conversion_done_in,
    .pointer_load_out, .hreadyout_out, .hresp_out, .stack_pointer_in, .next_pointer_out,
    .first_converter_channel_out, .second_converter_channel_out, .hrdata_out);

// >>> verification/sse_seq_model.sv
`timescale 1ns/1ps
module sse_seq_model (
    input  wire logic       clock_in, rst_in, step_in, jump_in, load_in,
    input  wire logic [4:0] next_in, jump_to_in,
    output logic [4:0]      stack_pointer_out,
    output logic            done_out
);
    // A conversion ends one cycle after the bench asks, so the bench sets the pace
    always_ff @(posedge clock_in) begin
        done_out <= step_in && !rst_in;
        if (jump_in) begin
            stack_pointer_out <= jump_to_in;
        end else if (load_in) begin
            stack_pointer_out <= next_in;
        end
    end
endmodule // sse_seq_model

// >>> verification/sse_stack_entries_tb.sv
`timescale 1ns/1ps
module sse_stack_entries_tb;
    import sse_pkg::*;
    logic        clock_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0, step = 0, jump = 0;
    logic        hready_in, conversion_done_in, pointer_load_out, hreadyout_out, hresp_out;
    logic [1:0]  htrans_in = 2'h0;
    logic [2:0]  hsize_in = 3'h2;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, r;
    logic [4:0]  stack_pointer_in, next_pointer_out, p, jump_to = 5'h00;
    logic [3:0]  first_converter_channel_out, second_converter_channel_out;
    logic [15:0] e30, e31;
    int          seed = 23, miscompares = 0, n_checks = 0;
    assign hready_in = hreadyout_out;
    always #10 clock_in = ~clock_in;
    sse_stack_entries sse_stack_entries_inst (.clock_in, .rst_in, .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .stack_pointer_in,
        .conversion_done_in, .hrdata_out, .hreadyout_out, .hresp_out, .next_pointer_out,
        .pointer_load_out, .first_converter_channel_out, .second_converter_channel_out);
    sse_seq_model sse_seq_model_inst (.clock_in, .rst_in, .step_in(step), .jump_in(jump),
        .load_in(pointer_load_out), .next_in(next_pointer_out), .jump_to_in(jump_to),
        .stack_pointer_out(stack_pointer_in), .done_out(conversion_done_in));
    function automatic logic [4:0] nxt(logic [4:0] q, logic [15:0] e);
        return e[8] ? 5'h00 : q + 5'h01;
    endfunction
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(logic wr, logic [7:0] a, logic [15:0] wd);
        @(posedge clock_in);
        hsel_in <= 1'b1;
        haddr_in <= {22'h0, a, 2'b00};
        htrans_in <= SSE_HTRANS_NONSEQ;
        hwrite_in <= wr;
        do @(posedge clock_in); while (hready_in !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= {16'h0, wd};
        do @(posedge clock_in); while (hready_in !== 1'b1);
        r = hrdata_out;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        bus(0, SSE_ADDR_ENTRY_30, 16'h0); chk("entry30 reset", r, 32'h7C00);
        bus(0, 8'h10, 16'h0); chk("unmapped", r, 32'h0);
        repeat (12) begin
            e30 = {1'b1, SSE_SELF_30, 9'($random(seed))};
            e31 = {1'b1, SSE_SELF_31, 9'($random(seed))};
            bus(1, SSE_ADDR_ENTRY_30, e30);
            bus(1, SSE_ADDR_ENTRY_31, e31);
            bus(0, SSE_ADDR_ENTRY_30, 16'h0); chk("entry30", r, {16'h0, e30});
            bus(0, SSE_ADDR_ENTRY_31, 16'h0); chk("entry31", r, {16'h0, e31});
            jump <= 1'b1;
            jump_to <= SSE_INDEX_30;
            @(posedge clock_in) jump <= 1'b0;
            repeat (2) @(posedge clock_in);
            chk("first channel", first_converter_channel_out, e30[3:0]);
            chk("second channel", second_converter_channel_out, e30[7:4]);
            p = SSE_INDEX_30;
            // Second step starts at 31 or at an entry this block must ignore
            repeat (2) begin
                step <= 1'b1;
                @(posedge clock_in) step <= 1'b0;
                repeat (3) @(posedge clock_in);
                p = (p[4:1] == 4'hF) ? nxt(p, p[0] ? e31 : e30) : p;
                chk("pointer", stack_pointer_in, p);
            end
        end
        jump <= 1'b1;
        jump_to <= SSE_INDEX_31;
        @(posedge clock_in) jump <= 1'b0;
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in) chk("pointer after reset", stack_pointer_in, 5'h00);
        bus(0, SSE_ADDR_ENTRY_31, 16'h0); chk("entry31 reset", r, 32'h7E00);
        bus(0, SSE_ADDR_STATUS, 16'h0); chk("status after reset", r, 32'h0);
        end_of_test;
    end
endmodule // sse_stack_entries_tb
